// >>> design/ast_pkg.sv
// package: constants and types of the async serial transmitter
package ast_pkg;

  // ------------------------------------------------------------------
  // register map, byte addresses on the register bus
  // ------------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_BAUD   = 8'h04;
  localparam logic [7:0]  ADDR_TXDATA = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0C;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------------
  localparam int          CTRL_W      = 7;
  localparam int          BAUD_W      = 16;
  localparam int          CHAR_W      = 9;
  localparam int          ST_FLAG_BIT = 0;
  localparam int          ST_BUSY_BIT = 1;
  localparam int          ST_OE_BIT   = 2;
  localparam logic [15:0] BAUD_RST    = 16'h0000;
  localparam logic [3:0]  LAST_BIT_8  = 4'h7;
  localparam logic [3:0]  LAST_BIT_9  = 4'h8;
  localparam int          BUF_DEPTH   = 2;

  // control word, bit 0 is tx_en
  typedef struct packed {
    logic brg16;
    logic stop2;
    logic polarity;
    logic nine_bit;
    logic port_en;
    logic sync_mode;
    logic tx_en;
  } ast_ctrl_t;

  localparam ast_ctrl_t CTRL_RST = 7'h00;

  // one character: optional ninth bit above eight data bits
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ast_char_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_START = 2'h1,
    ST_DATA  = 2'h2,
    ST_STOP  = 2'h3
  } ast_state_t;

endpackage

// >>> design/ast_buf2.sv
// two-entry holding buffer between the register bus and the shift register
`timescale 1ns/1ps
`default_nettype none

module ast_buf2 (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_flush,
  // filling side
  input  wire logic              i_in_valid,
  output logic                   o_in_ready,
  input  wire ast_pkg::ast_char_t i_in_data,
  // draining side
  output logic                   o_out_valid,
  input  wire logic              i_out_ready,
  output ast_pkg::ast_char_t     o_out_data
);
  import ast_pkg::*;

  ast_char_t  mem_reg [BUF_DEPTH];
  logic       wr_ptr_reg;
  logic       rd_ptr_reg;
  logic [1:0] count_reg;
  logic       push;
  logic       pop;

  assign o_in_ready  = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready && !i_flush;
  assign pop         = o_out_valid && i_out_ready && !i_flush;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  for (genvar g = 0; g < BUF_DEPTH; g++) begin : g_entry
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        mem_reg[g] <= '0;
      end else if (push && (wr_ptr_reg == 1'(g))) begin
        mem_reg[g] <= i_in_data;
      end
    end
  end

  // ------------------------------------------------------------------
  // pointers and occupancy
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_flush) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

  chk_buf_no_overfill: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (count_reg == 2'h2 && !pop && !i_flush) |=> (count_reg == 2'h2))
    else $error("buffer occupancy dropped without a pop");

endmodule

`default_nettype wire

// >>> design/ast_tx.sv
// async serial transmitter: register slave, rate generator, frame shifter
//
// Operation
// - idle line held at mark level
// - start, eight or nine data, stop bits
// - start bit space, stop bits mark
// - each bit lasts one baud period
// - baud period from 8-bit or 16-bit counter
// - data bits least significant first after start
// - shared format and rate, paths independent
// - no hardware parity; ninth bit from software
// - shift register fed only from holding buffer
// - enable and port enable bits activate; sync clear means async
// - port enable drives pin as output
// - empty flag sets when transmitter enabled
// - refill at once or right after stop begins
// - flag set when enabled, nothing waiting behind a busy shifter; read-only
// - flag valid from second cycle after write
// - polarity bit inverts output; resets to zero
`timescale 1ns/1ps
`default_nettype none

module ast_tx (
  // clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_sys_rst,
  // register bus write address and data
  input  wire logic [ast_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                      i_s_axi_awvalid,
  output logic                           o_s_axi_awready,
  input  wire logic [31:0]               i_s_axi_wdata,
  input  wire logic [3:0]                i_s_axi_wstrb,
  input  wire logic                      i_s_axi_wvalid,
  output logic                           o_s_axi_wready,
  // register bus write response
  output logic [1:0]                     o_s_axi_bresp,
  output logic                           o_s_axi_bvalid,
  input  wire logic                      i_s_axi_bready,
  // register bus read
  input  wire logic [ast_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                      i_s_axi_arvalid,
  output logic                           o_s_axi_arready,
  output logic [31:0]                    o_s_axi_rdata,
  output logic [1:0]                     o_s_axi_rresp,
  output logic                           o_s_axi_rvalid,
  input  wire logic                      i_s_axi_rready,
  // serial output pin and flag
  output logic                           o_tx_pin,
  output logic                           o_tx_oe,
  output logic                           o_buf_empty_flag
);
  import ast_pkg::*;

  // word decode shared by the read and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  ast_ctrl_t          ctrl_reg;
  logic [BAUD_W-1:0]  baud_reg;
  logic               aw_full_reg;
  logic               w_full_reg;
  logic [ADDR_W-1:0]  aw_addr_reg;
  logic [31:0]        w_data_reg;
  logic [3:0]         w_strb_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic               rvalid_reg;
  logic [31:0]        rdata_reg;
  logic [1:0]         rresp_reg;
  logic               wr_is_tx;
  logic               wr_mapped;
  logic               wr_fire;
  logic               rd_mapped;
  logic [31:0]        rd_word;
  logic               active;
  logic               buf_in_valid;
  logic               buf_in_ready;
  logic               buf_out_valid;
  logic               buf_out_ready;
  ast_char_t          buf_in_data;
  ast_char_t          buf_out_data;
  ast_state_t         state_reg;
  logic [BAUD_W-1:0]  period_m1;
  logic [BAUD_W-1:0]  cnt_reg;
  logic               tick;
  logic [3:0]         bit_cnt_reg;
  logic [3:0]         last_bit;
  logic               stop_cnt_reg;
  logic               last_data;
  logic               last_stop;
  logic [CHAR_W-1:0]  sh_data_reg;
  logic               sh_full_reg;
  logic               pop;
  logic               line_c;
  logic               pin_reg;
  logic               oe_reg;
  logic               flag_reg;
  logic [BAUD_W-1:0]  hold_reg;

  // ------------------------------------------------------------------
  // register bus: write channel
  // ------------------------------------------------------------------
  assign o_s_axi_awready = !aw_full_reg;
  assign o_s_axi_wready  = !w_full_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign wr_is_tx  = reg_hit(aw_addr_reg, ADDR_TXDATA);
  assign wr_mapped = reg_hit(aw_addr_reg, ADDR_CTRL) || reg_hit(aw_addr_reg, ADDR_BAUD)
                     || wr_is_tx || reg_hit(aw_addr_reg, ADDR_STATUS);
  // a full buffer stalls the response, so back-pressure reaches the master
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg
                   && (!wr_is_tx || !ctrl_reg.tx_en || buf_in_ready);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (i_s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (i_s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= i_s_axi_wdata;
      w_strb_reg <= i_s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // control and rate registers; polarity and all enables reset to zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_reg <= CTRL_RST;
      baud_reg <= BAUD_RST;
    end else if (wr_fire) begin
      if (reg_hit(aw_addr_reg, ADDR_CTRL) && w_strb_reg[0]) begin
        ctrl_reg <= ast_ctrl_t'(w_data_reg[CTRL_W-1:0]);
      end
      if (reg_hit(aw_addr_reg, ADDR_BAUD)) begin
        if (w_strb_reg[0]) begin
          baud_reg[7:0] <= w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
          baud_reg[15:8] <= w_data_reg[15:8];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // register bus: read channel
  // ------------------------------------------------------------------
  assign o_s_axi_arready = !rvalid_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;
  assign rd_mapped = reg_hit(i_s_axi_araddr, ADDR_CTRL) || reg_hit(i_s_axi_araddr, ADDR_BAUD)
                     || reg_hit(i_s_axi_araddr, ADDR_TXDATA)
                     || reg_hit(i_s_axi_araddr, ADDR_STATUS);

  // the shift register is never visible; the data address reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (reg_hit(i_s_axi_araddr, ADDR_CTRL)) begin
      rd_word[CTRL_W-1:0] = ctrl_reg;
    end else if (reg_hit(i_s_axi_araddr, ADDR_BAUD)) begin
      rd_word[BAUD_W-1:0] = baud_reg;
    end else if (reg_hit(i_s_axi_araddr, ADDR_STATUS)) begin
      rd_word[ST_FLAG_BIT] = flag_reg;
      rd_word[ST_BUSY_BIT] = (state_reg != ST_IDLE) || sh_full_reg;
      rd_word[ST_OE_BIT]   = oe_reg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (i_s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // holding buffer
  // ------------------------------------------------------------------
  // async only: sync mode or a missing enable keeps the shifter parked
  assign active        = ctrl_reg.tx_en && !ctrl_reg.sync_mode && ctrl_reg.port_en;
  assign buf_in_valid  = wr_fire && wr_is_tx && ctrl_reg.tx_en;
  // software supplies the ninth bit, parity included if wanted
  assign buf_in_data   = {w_data_reg[8], w_data_reg[7:0]};
  assign buf_out_ready = !sh_full_reg && active;
  assign pop           = buf_out_valid && buf_out_ready;

  ast_buf2 u_hold (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_flush     (!ctrl_reg.tx_en),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (buf_in_data),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_out_ready),
    .o_out_data  (buf_out_data)
  );

  // while enabled, flag is low only while a character waits behind a busy shifter
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= ctrl_reg.tx_en && !(buf_out_valid && sh_full_reg);
    end
  end

  // ------------------------------------------------------------------
  // rate generator
  // ------------------------------------------------------------------
  // one format and one rate setting serve any receive path as well
  assign period_m1 = ctrl_reg.brg16 ? baud_reg : {8'h00, baud_reg[7:0]};
  assign tick      = (state_reg != ST_IDLE) && (cnt_reg == '0);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= BAUD_RST;
    end else if (state_reg == ST_IDLE || cnt_reg == '0) begin
      cnt_reg <= period_m1;
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------------
  assign last_bit  = ctrl_reg.nine_bit ? LAST_BIT_9 : LAST_BIT_8;
  assign last_data = tick && (state_reg == ST_DATA) && (bit_cnt_reg == last_bit);
  assign last_stop = tick && (state_reg == ST_STOP) && (stop_cnt_reg == ctrl_reg.stop2);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !active) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (sh_full_reg) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (last_data) begin
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (last_stop) begin
            state_reg <= sh_full_reg ? ST_START : ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || state_reg != ST_DATA) begin
      bit_cnt_reg <= 4'h0;
    end else if (tick) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || state_reg != ST_STOP) begin
      stop_cnt_reg <= 1'b0;
    end else if (tick) begin
      stop_cnt_reg <= !stop_cnt_reg;
    end
  end

  // shifter empties on its last data bit, so the next character loads as
  // soon as the stop bit has begun and rides out the stop time in place
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !active) begin
      sh_full_reg <= 1'b0;
    end else if (pop) begin
      sh_full_reg <= 1'b1;
    end else if (last_data) begin
      sh_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sh_data_reg <= '0;
    end else if (pop) begin
      sh_data_reg <= buf_out_data;
    end else if (tick && state_reg == ST_DATA) begin
      sh_data_reg <= {1'b0, sh_data_reg[CHAR_W-1:1]};
    end
  end

  // ------------------------------------------------------------------
  // line level and pin
  // ------------------------------------------------------------------
  always_comb begin
    case (state_reg)
      ST_START: line_c = 1'b0;
      ST_DATA:  line_c = sh_data_reg[0];
      ST_STOP:  line_c = 1'b1;
      default:  line_c = 1'b1;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= line_c ^ ctrl_reg.polarity;
    end
  end

  // analog takeover of the pin is software's job; we only claim the driver
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= ctrl_reg.port_en;
    end
  end

  assign o_tx_pin         = pin_reg;
  assign o_tx_oe          = oe_reg;
  assign o_buf_empty_flag = flag_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || state_reg == ST_IDLE || tick) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  chk_idle_mark: assert property (
    (state_reg == ST_IDLE) |=> (o_tx_pin != $past(ctrl_reg.polarity)))
    else $error("idle line not at mark");
  chk_start_space: assert property (
    (state_reg == ST_START) |=> (o_tx_pin != $past(ctrl_reg.polarity)) == 1'b0)
    else $error("start bit not at space");
  chk_stop_mark: assert property (
    (state_reg == ST_STOP) |=> (o_tx_pin ^ $past(ctrl_reg.polarity)) == 1'b1)
    else $error("stop bit not at mark");
  chk_bit_period: assert property (
    (tick && $stable(period_m1)) |-> (hold_reg == period_m1))
    else $error("bit length differs from baud period");
  chk_lsb_first: assert property (
    (state_reg == ST_START && tick) ##1 (state_reg == ST_DATA)
    |=> (o_tx_pin ^ $past(ctrl_reg.polarity)) == $past(sh_data_reg[0], 2))
    else $error("first data bit is not the lsb");
  chk_frame_len: assert property (
    (state_reg == ST_DATA && tick && bit_cnt_reg < last_bit && active)
    |=> (state_reg == ST_DATA))
    else $error("frame left data phase early");
  chk_refill: assert property (
    (last_data && buf_out_valid && active) |=> ##1 sh_full_reg)
    else $error("pending character not moved after stop began");
  chk_flag_state: assert property (
    $rose(ctrl_reg.tx_en) |=> o_buf_empty_flag)
    else $error("empty flag not set on enable");
  chk_pin_drive: assert property (
    $rose(ctrl_reg.port_en) |=> o_tx_oe)
    else $error("pin not driven after port enable");

  cov_frame_done: cover property (last_stop && !sh_full_reg);
  cov_back_to_back: cover property (last_stop && sh_full_reg);
  cov_nine_bit: cover property (last_data && ctrl_reg.nine_bit);
  cov_inverted: cover property (tick && ctrl_reg.polarity && ctrl_reg.stop2);

endmodule

`default_nettype wire

// >>> tb/ast_rx_model.sv
// remote asynchronous receiver model watching the serial line
`timescale 1ns/1ps
`default_nettype none

module ast_rx_model (
  // clock and mode
  input  wire logic        i_core_clk,
  input  wire logic        i_en,
  input  wire logic        i_pol,
  input  wire logic        i_nine,
  input  wire logic [16:0] i_period,
  // serial line
  input  wire logic        i_line,
  // decoded result
  output logic [8:0]       o_char,
  output logic             o_stop_ok,
  output logic [31:0]      o_span,
  output logic [31:0]      o_frames
);
  // ------------------------------------------------------------------
  // frame decoder
  // ------------------------------------------------------------------
  logic        ln;
  logic        ok;
  logic [8:0]  c;
  logic [31:0] cnt;
  logic [31:0] last;

  // mark seen as one whatever the polarity
  assign ln = i_line ^ i_pol;

  initial begin
    o_char = '0;
    o_stop_ok = 1'b0;
    o_span = '0;
    o_frames = '0;
    cnt = '0;
    last = '0;
  end

  always @(posedge i_core_clk) cnt <= cnt + 32'h1;

  // samples on falling clock edges, away from the line's update edge
  always begin
    wait (i_en && !ln);
    @(negedge i_core_clk);
    o_span = cnt - last;
    last = cnt;
    c = '0;
    repeat ((i_period - 17'h1) >> 1) @(negedge i_core_clk);
    ok = !ln;
    for (int b = 0; b < 9; b++) begin
      if (b < 8 || i_nine) begin
        repeat (i_period) @(negedge i_core_clk);
        c[b] = ln;
      end
    end
    repeat (i_period) @(negedge i_core_clk);
    o_stop_ok = ok && ln;
    o_char = c;
    o_frames = o_frames + 32'h1;
  end
endmodule
`default_nettype wire

// >>> tb/ast_tx_tb.sv
// self-checking bench of the async serial transmitter
`timescale 1ns/1ps
`default_nettype none

module ast_tx_tb;
  import ast_pkg::*;
  // ------------------------------------------------------------------
  // signals, design and receiver
  // ------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, span, frames;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pin, oe, flag, stop_ok;
  logic [1:0]  bresp, rresp;
  logic        en = 1'b0, pol = 1'b0, nine = 1'b0;
  logic [16:0] per = 17'h4;
  logic [8:0]  rch;
  int          err_total = 0, n_checks = 0, nrx = 0;

  always #20 clk = ~clk;

  ast_tx i_ast_tx (.i_core_clk(clk), .i_sys_rst(rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_tx_pin(pin), .o_tx_oe(oe), .o_buf_empty_flag(flag));

  ast_rx_model i_ast_rx_model (.i_core_clk(clk), .i_en(en), .i_pol(pol), .i_nine(nine),
    .i_period(per), .i_line(pin), .o_char(rch), .o_stop_ok(stop_ok), .o_span(span),
    .o_frames(frames));

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // a full write buffer holds the response back for up to one character
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 5000);
    bready <= 1'b0;
    if (n >= 5000) begin
      chk("write wait", 32'h1, 32'h0);
      summarize();
    end
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e,
                    input logic cd);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    if (n >= 100) begin
      chk("read wait", 32'h1, 32'h0);
      summarize();
    end
    chk("rresp", 32'(er), 32'(rresp));
    if (cd) chk("rdata", e, rdata);
  endtask

  // span is the start-to-start distance, zero when not checked
  task automatic rx(input logic [8:0] e, input logic [31:0] es);
    int n;
    for (n = 0; n < 20000 && frames === 32'(nrx); n++) @(posedge clk);
    if (n >= 20000) begin
      chk("frame wait", 32'h1, 32'h0);
      summarize();
    end
    nrx++;
    chk("rx char", 32'(e), 32'(rch));
    chk("stop level", 32'h1, 32'(stop_ok));
    if (es != 32'h0) chk("frame span", es, span);
  endtask

  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    chk("idle pin", 32'h1, 32'(pin));
    chk("flag at reset", 32'h0, 32'(flag));
    rd(ADDR_CTRL, RESP_OKAY, 32'h0, 1'b1);
    rd(8'h10, RESP_SLVERR, 32'h0, 1'b0);
    wr(ADDR_TXDATA, 32'h55, RESP_OKAY);
    wr(ADDR_BAUD, 32'h103, RESP_OKAY);
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    cyc(2);
    chk("flag on enable", 32'h1, 32'(flag));
    chk("oe on enable", 32'h1, 32'(oe));
    en <= 1'b1;
    wr(ADDR_TXDATA, 32'hA5, RESP_OKAY);
    wr(ADDR_TXDATA, 32'h3C, RESP_OKAY);
    cyc(2);
    chk("flag queued", 32'h0, 32'(flag));
    wr(ADDR_TXDATA, 32'h1, RESP_OKAY);
    rx(9'h0A5, 32'h0);
    rx(9'h03C, 32'h28);
    rx(9'h001, 32'h28);
    cyc(8);
    chk("idle after stop", 32'h1, 32'(pin));
    wr(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY, 32'h5, 1'b1);
    rd(ADDR_TXDATA, RESP_OKAY, 32'h0, 1'b1);
    en <= 1'b0;
    wr(ADDR_CTRL, 32'h3D, RESP_OKAY);
    pol <= 1'b1;
    nine <= 1'b1;
    cyc(3);
    chk("inverted idle", 32'h0, 32'(pin));
    en <= 1'b1;
    wr(ADDR_TXDATA, 32'h12B, RESP_OKAY);
    wr(ADDR_TXDATA, 32'hD4, RESP_OKAY);
    rx(9'h12B, 32'h0);
    rx(9'h0D4, 32'h30);
    // let both stop bits finish before the rate and format change
    cyc(10);
    en <= 1'b0;
    wr(ADDR_CTRL, 32'h45, RESP_OKAY);
    pol <= 1'b0;
    nine <= 1'b0;
    per <= 17'h104;
    cyc(3);
    en <= 1'b1;
    wr(ADDR_TXDATA, 32'h5A, RESP_OKAY);
    rx(9'h05A, 32'h0);
    per <= 17'h4;
    wr(ADDR_CTRL, 32'h7, RESP_OKAY);
    wr(ADDR_TXDATA, 32'h33, RESP_OKAY);
    cyc(100);
    chk("frames in sync mode", 32'(nrx), frames);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    cyc(2);
    chk("oe off", 32'h0, 32'(oe));
    chk("flag off", 32'h0, 32'(flag));
    summarize();
  end
endmodule
`default_nettype wire
